/* File: logic/csa_pkg.sv */
// shared constants, types and helpers for the cpu stack/alu/flags datapath
// assumes a 4-bit data memory of two 256-word banks and a 12-bit return address
package csa_pkg;
  // ==========================================================
  // widths and memory map
  localparam int DATA_W = 4;
  localparam int PC_W = 12;
  localparam int ADDR_W = 9;
  localparam int RAM_DEPTH = 512;
  localparam logic [7:0] STACK_BASE = 8'hC0;
  localparam logic [7:0] TPTR_ADDR = 8'hFC;
  localparam logic [7:0] SLP_ADDR = 8'hFF;
  localparam logic [2:0] CALL_WORDS = 3'h3;
  localparam logic [2:0] INT_WORDS = 3'h4;
  localparam logic SF_RESET = 1'b1;
  localparam logic ROM_TABLE_MSB = 1'b1;

  // ==========================================================
  // commands, alu functions, sequencer states
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_LD_A_MEM = 5'h01, OP_LD_A_IMM = 5'h02, OP_ST_A_MEM = 5'h03,
    OP_ST_IMM_MEM = 5'h04, OP_ADD_IMM = 5'h05, OP_ADD_WITH_CARRY_MEM = 5'h06,
    OP_REVERSE_SUBTRACT_WITH_CARRY_MEM = 5'h07, OP_COMPARE_OP_MEM = 5'h08, OP_COMPARE_OP_IMM = 5'h09,
    OP_AND_MEM = 5'h0A, OP_OR_MEM = 5'h0B, OP_XOR_MEM = 5'h0C, OP_DEC_A = 5'h0D,
    OP_ROTATE_LEFT_THROUGH_CARRY = 5'h0E, OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h0F, OP_CARRY_TEST_AND_SET = 5'h10, OP_CARRY_TEST_AND_CLEAR = 5'h11,
    OP_CALL = 5'h12, OP_INT = 5'h13, OP_RET = 5'h14, OP_INTERRUPT_RETURN = 5'h15,
    OP_BRANCH = 5'h16, OP_LDL = 5'h17, OP_LDH = 5'h18
  } csa_op_type;

  typedef enum logic [2:0] {
    ALU_PASS = 3'h0, ALU_ADD = 3'h1, ALU_SUB = 3'h2, ALU_AND = 3'h3,
    ALU_OR = 3'h4, ALU_XOR = 3'h5, ALU_ROL = 3'h6, ALU_ROR = 3'h7
  } csa_alu_type;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_EXEC = 5'b00010, S_ROM = 5'b00100,
    S_PUSH = 5'b01000, S_POP = 5'b10000
  } csa_state_type;

  // ==========================================================
  // address helpers
  // true for bank 0 words held in flops, not in the ram
  function automatic logic is_special(input logic [8:0] a);
    return (a[8] == 1'b0) && (a[7:0] >= TPTR_ADDR);
  endfunction

  // bank 0 address of word w of stack level lvl
  function automatic logic [8:0] stack_addr(input logic [3:0] lvl, input logic [2:0] w);
    logic [7:0] s;
    s = STACK_BASE + {2'b00, lvl, 2'b00} + {5'b00000, w};
    return {1'b0, s};
  endfunction
endpackage

/* File: logic/csa_alu_if.sv */
// operand and result bundle between the core sequencer and the alu
// assumes one core and one alu per bundle
`timescale 1ns/1ps
`default_nettype none
interface csa_alu_if;
  import csa_pkg::*;
  logic [DATA_W-1:0] x;
  logic [DATA_W-1:0] y;
  logic cin;
  csa_alu_type fn;
  logic [DATA_W-1:0] res;
  logic cout;
  logic zero;
  modport core (output x, output y, output cin, output fn, input res, input cout, input zero);
  modport alu (input x, input y, input cin, input fn, output res, output cout, output zero);
endinterface
`default_nettype wire

/* File: logic/csa_alu.sv */
// combinational 4-bit alu with carry and zero detect
// assumes the core registers everything it takes from here
`timescale 1ns/1ps
`default_nettype none
module csa_alu import csa_pkg::*; (
  csa_alu_if.alu bus // operands in, result out
);
  // ==========================================================
  // arithmetic, logic and rotate through carry
  logic [DATA_W:0] sum;
  always_comb begin
    sum = {1'b0, bus.x} + {1'b0, bus.y} + {4'h0, bus.cin};
    bus.res = bus.x;
    bus.cout = 1'b0;
    case (bus.fn)
      ALU_ADD: begin
        {bus.cout, bus.res} = sum; // carry out of msb
      end
      ALU_SUB: begin
        sum = {1'b0, bus.x} + {1'b0, ~bus.y} + {4'h0, bus.cin};
        {bus.cout, bus.res} = sum; // carry means no borrow
      end
      ALU_AND: bus.res = bus.x & bus.y;
      ALU_OR: bus.res = bus.x | bus.y;
      ALU_XOR: bus.res = bus.x ^ bus.y;
      ALU_ROL: begin
        bus.res = {bus.x[2:0], bus.cin};
        bus.cout = bus.x[3]; // bit shifted out
      end
      ALU_ROR: begin
        bus.res = {bus.cin, bus.x[3:1]};
        bus.cout = bus.x[0];
      end
      default: bus.res = bus.x;
    endcase
    bus.zero = (bus.res == 4'h0); // RULE_18
  end
endmodule
`default_nettype wire

/* File: logic/csa_ram.sv */
// simple dual-port data memory, registered read
// assumes one write and one read per clock, write and read independent
`timescale 1ns/1ps
`default_nettype none
module csa_ram #(
  parameter int WORDS = 512,
  parameter int WIDTH = 4,
  parameter int AW = 9
) (
  input wire logic clk, // system clock
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write address
  input wire logic [WIDTH-1:0] wdata, // write data
  input wire logic [AW-1:0] raddr, // read address
  output logic [WIDTH-1:0] rdata_r // read data, one cycle later
);
  logic [WIDTH-1:0] mem [WORDS];

  // ==========================================================
  // storage, contents undefined after power-up
  always_ff @(posedge clk) begin
    if (we && (int'(waddr) < WORDS)) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_r <= (int'(raddr) < WORDS) ? mem[raddr] : '0;
  end
endmodule
`default_nettype wire

/* File: logic/csa_core.sv */
// cpu datapath core: return stack in data memory, table pointer, alu, acc, flags
// assumes one command at a time, taken while busy_r is low; rom data one cycle after request
//
// How it works
// (RULE_01) call pushes pc only; interrupt pushes pc plus flags
// (RULE_02) plain return restores pc; interrupt return restores pc and flags
// (RULE_03) fifteen stack levels of four words each in bank 0
// (RULE_04) level pointer decrements after save, increments before restore
// (RULE_05) level pointer lives at bank 0 word FF
// (RULE_06) software keeps level pointer within 0..12 normally, never 15
// (RULE_07) level pointer is not reset; software loads it, usually 12
// (RULE_08) no overflow check; deep pushes overwrite user data
// (RULE_09) 12-bit table pointer addresses program memory for table reads
// (RULE_10) tables live from program address 1000 upward
// (RULE_11) table pointer is read and written as data memory nibbles
// (RULE_12) timer count words share stack levels 13 and 14
// (RULE_13) deep stack levels only usable when matching timers are idle
// (RULE_14) words F7 and FB stay plain ram
// (RULE_15) first sixteen bank 0 words reachable by zero-page addressing
// (RULE_16) alu takes 4-bit operands, gives result, carry and zero
// (RULE_17) carry is add carry, subtract no-borrow, rotate shifted-out bit
// (RULE_18) zero detect is 1 when result or moved value is 0000
// (RULE_19) carry flag feeds alu for carry ops and rotates, then captures carry
// (RULE_20) test-and-set copies carry to branch flag then sets carry
// (RULE_21) test-and-clear copies inverted carry to branch flag then clears carry
// (RULE_22) zero flag captures zero detect on alu, rotate, load to acc
// (RULE_23) branch taken only when branch flag is 1
// (RULE_24) reset sets branch flag; carry and zero flags keep their value
`timescale 1ns/1ps
`default_nettype none
module csa_core import csa_pkg::*; #(
  parameter int RAM_WORDS = RAM_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic op_valid, // command present
  input wire csa_op_type op, // command code
  input wire logic [ADDR_W-1:0] mem_addr, // {bank, address}
  input wire logic zero_page, // use zero-page form of mem_addr
  input wire logic [DATA_W-1:0] imm, // immediate operand
  input wire logic [PC_W-1:0] pc_in, // return address to save
  input wire logic [7:0] rom_data, // program memory byte
  output logic busy_r, // command in progress
  output logic done_r, // command finished, one cycle
  output logic [DATA_W-1:0] acc_r, // accumulator
  output logic carry_flag_r, // carry flag
  output logic zero_result_flag_r, // zero flag
  output logic branch_condition_flag_r, // branch condition flag
  output logic branch_taken_r, // branch decision, one cycle
  output logic [PC_W-1:0] pc_out_r, // restored program counter
  output logic pc_load_r, // restored pc valid, one cycle
  output logic [12:0] rom_addr_r, // program memory address
  output logic rom_req_r // program memory read, one cycle
);
  // ==========================================================
  // parameter check
  if (RAM_WORDS < 256 || RAM_WORDS > RAM_DEPTH) begin : g_bad_depth
    $error("csa_core: RAM_WORDS out of range");
  end

  csa_state_type state_r, state_nxt;
  csa_op_type op_r;
  logic [ADDR_W-1:0] addr_r, raddr, wr_addr;
  logic [DATA_W-1:0] imm_r, spw_r, mem_val, opnd, ram_rdata, spec_data_r, wr_data;
  logic [PC_W-1:0] pc_r, dc_r, pc_acc_r;
  logic [2:0] cnt_r, nwords;
  logic spec_hit_r, accept, wr_any, last;
  csa_alu_if alu_bus ();

  csa_alu u_alu (
    .bus(alu_bus.alu)
  );

  csa_ram #(.WORDS(RAM_WORDS), .WIDTH(DATA_W), .AW(ADDR_W)) u_ram (
    .clk(clk),
    .we(wr_any && !is_special(wr_addr)), // RULE_12 RULE_14
    .waddr(wr_addr),
    .wdata(wr_data),
    .raddr(raddr),
    .rdata_r(ram_rdata)
  );

  assign accept = op_valid && (state_r == S_IDLE);
  assign nwords = (op_r == OP_INT || op_r == OP_INTERRUPT_RETURN) ? INT_WORDS : CALL_WORDS; // RULE_01
  assign last = (cnt_r == nwords - 3'h1);

  // ==========================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (accept) begin
          case (op)
            OP_CALL, OP_INT: state_nxt = S_PUSH;
            OP_RET, OP_INTERRUPT_RETURN: state_nxt = S_POP;
            OP_LDL, OP_LDH: state_nxt = S_ROM;
            default: state_nxt = S_EXEC;
          endcase
        end
      end
      S_ROM: state_nxt = S_EXEC;
      S_EXEC: state_nxt = S_IDLE;
      S_PUSH: state_nxt = last ? S_IDLE : S_PUSH;
      S_POP: state_nxt = (cnt_r == nwords) ? S_IDLE : S_POP;
      default: state_nxt = S_IDLE;
    endcase
  end

  // state, command latch, word counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      op_r <= OP_NOP;
      addr_r <= '0;
      imm_r <= '0;
      pc_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != S_IDLE);
      cnt_r <= (state_r == S_PUSH || state_r == S_POP) ? cnt_r + 3'h1 : 3'h0;
      if (accept) begin
        op_r <= op;
        addr_r <= zero_page ? {5'h00, mem_addr[3:0]} : mem_addr; // RULE_15
        imm_r <= imm;
        pc_r <= pc_in;
      end
    end
  end

  // ==========================================================
  // data memory read and write paths
  always_comb begin
    raddr = zero_page ? {5'h00, mem_addr[3:0]} : mem_addr;
    if (state_r == S_POP) begin
      raddr = stack_addr(spw_r, cnt_r); // RULE_03
    end
    wr_any = 1'b0;
    wr_addr = addr_r;
    wr_data = acc_r;
    if (state_r == S_EXEC && op_r == OP_ST_A_MEM) begin
      wr_any = 1'b1;
    end else if (state_r == S_EXEC && op_r == OP_ST_IMM_MEM) begin
      wr_any = 1'b1;
      wr_data = imm_r;
    end else if (state_r == S_PUSH) begin
      wr_any = 1'b1; // no bound check on level // RULE_08
      wr_addr = stack_addr(spw_r, cnt_r); // RULE_03
      case (cnt_r)
        3'h0: wr_data = pc_r[3:0];
        3'h1: wr_data = pc_r[7:4];
        3'h2: wr_data = pc_r[11:8];
        default: wr_data = {1'b0, carry_flag_r, zero_result_flag_r, branch_condition_flag_r};
      endcase
    end
  end

  // flop-held words answer reads in place of the ram
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spec_hit_r <= 1'b0;
      spec_data_r <= '0;
    end else begin
      spec_hit_r <= is_special(raddr);
      case (raddr[1:0])
        2'h0: spec_data_r <= dc_r[3:0]; // RULE_11
        2'h1: spec_data_r <= dc_r[7:4];
        2'h2: spec_data_r <= dc_r[11:8];
        default: spec_data_r <= spw_r;
      endcase
    end
  end

  assign mem_val = spec_hit_r ? spec_data_r : ram_rdata;

  // ==========================================================
  // level pointer and table pointer, left unreset
  always_ff @(posedge clk) begin
    if (wr_any && wr_addr == {1'b0, SLP_ADDR}) begin
      spw_r <= wr_data; // RULE_05
    end else if (state_r == S_PUSH && last) begin
      spw_r <= spw_r - 4'h1; // RULE_04
    end else if (accept && (op == OP_RET || op == OP_INTERRUPT_RETURN)) begin
      spw_r <= spw_r + 4'h1; // RULE_04
    end
  end

  always_ff @(posedge clk) begin
    if (wr_any && is_special(wr_addr) && wr_addr[1:0] != 2'h3) begin
      case (wr_addr[1:0])
        2'h0: dc_r[3:0] <= wr_data; // RULE_11
        2'h1: dc_r[7:4] <= wr_data;
        default: dc_r[11:8] <= wr_data;
      endcase
    end else if (state_r == S_EXEC && op_r == OP_LDH) begin
      dc_r <= dc_r + 12'h001; // post-increment after high read
    end
  end

  // ==========================================================
  // alu operand steering
  always_comb begin
    case (op_r)
      OP_LDL: opnd = rom_data[3:0];
      OP_LDH: opnd = rom_data[7:4];
      OP_LD_A_IMM, OP_ADD_IMM, OP_COMPARE_OP_IMM: opnd = imm_r;
      default: opnd = mem_val;
    endcase
    alu_bus.x = acc_r;
    alu_bus.y = opnd;
    alu_bus.cin = 1'b0;
    alu_bus.fn = ALU_PASS;
    case (op_r)
      OP_ADD_IMM: alu_bus.fn = ALU_ADD;
      OP_ADD_WITH_CARRY_MEM: begin
        alu_bus.fn = ALU_ADD;
        alu_bus.cin = carry_flag_r; // RULE_19
      end
      OP_REVERSE_SUBTRACT_WITH_CARRY_MEM: begin
        alu_bus.x = opnd;
        alu_bus.y = acc_r;
        alu_bus.fn = ALU_SUB;
        alu_bus.cin = carry_flag_r; // RULE_19
      end
      OP_COMPARE_OP_MEM, OP_COMPARE_OP_IMM: begin
        alu_bus.x = opnd;
        alu_bus.y = acc_r;
        alu_bus.fn = ALU_SUB;
        alu_bus.cin = 1'b1; // RULE_17
      end
      OP_AND_MEM: alu_bus.fn = ALU_AND;
      OP_OR_MEM: alu_bus.fn = ALU_OR;
      OP_XOR_MEM: alu_bus.fn = ALU_XOR;
      OP_DEC_A: begin
        alu_bus.y = 4'hF;
        alu_bus.fn = ALU_ADD;
      end
      OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        alu_bus.fn = (op_r == OP_ROTATE_LEFT_THROUGH_CARRY) ? ALU_ROL : ALU_ROR;
        alu_bus.cin = carry_flag_r; // RULE_19
      end
      default: alu_bus.x = opnd; // plain move, zero detect on moved value
    endcase
  end

  function automatic logic writes_acc(input csa_op_type o);
    case (o)
      OP_LD_A_MEM, OP_LD_A_IMM, OP_ADD_IMM, OP_ADD_WITH_CARRY_MEM, OP_REVERSE_SUBTRACT_WITH_CARRY_MEM, OP_AND_MEM,
      OP_OR_MEM, OP_XOR_MEM, OP_DEC_A, OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY, OP_LDL, OP_LDH: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // carry and zero flags keep their value through reset
  always_ff @(posedge clk) begin
    if (state_r == S_EXEC) begin
      case (op_r)
        OP_ADD_WITH_CARRY_MEM, OP_REVERSE_SUBTRACT_WITH_CARRY_MEM, OP_COMPARE_OP_MEM, OP_COMPARE_OP_IMM, OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY:
          carry_flag_r <= alu_bus.cout; // RULE_19
        OP_CARRY_TEST_AND_SET: carry_flag_r <= 1'b1; // RULE_20
        OP_CARRY_TEST_AND_CLEAR: carry_flag_r <= 1'b0; // RULE_21
        default: carry_flag_r <= carry_flag_r;
      endcase
      if (writes_acc(op_r) || op_r == OP_COMPARE_OP_MEM || op_r == OP_COMPARE_OP_IMM) begin
        zero_result_flag_r <= alu_bus.zero; // RULE_22
      end
    end else if (state_r == S_POP && op_r == OP_INTERRUPT_RETURN && cnt_r == INT_WORDS) begin
      carry_flag_r <= mem_val[2]; // RULE_02
      zero_result_flag_r <= mem_val[1];
    end
  end

  // branch condition flag, the only flag with a reset value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      branch_condition_flag_r <= SF_RESET; // RULE_24
    end else if (state_r == S_EXEC) begin
      case (op_r)
        OP_ADD_IMM, OP_ADD_WITH_CARRY_MEM, OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY:
          branch_condition_flag_r <= ~alu_bus.cout;
        OP_REVERSE_SUBTRACT_WITH_CARRY_MEM, OP_DEC_A: branch_condition_flag_r <= alu_bus.cout;
        OP_COMPARE_OP_MEM, OP_COMPARE_OP_IMM, OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM:
          branch_condition_flag_r <= ~alu_bus.zero;
        OP_CARRY_TEST_AND_SET: branch_condition_flag_r <= carry_flag_r; // RULE_20
        OP_CARRY_TEST_AND_CLEAR: branch_condition_flag_r <= ~carry_flag_r; // RULE_21
        default: branch_condition_flag_r <= 1'b1;
      endcase
    end else if (state_r == S_POP && op_r == OP_INTERRUPT_RETURN && cnt_r == INT_WORDS) begin
      branch_condition_flag_r <= mem_val[0]; // RULE_02
    end
  end

  // ==========================================================
  // accumulator, restored pc, rom request, strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
      pc_acc_r <= '0;
      pc_out_r <= '0;
      pc_load_r <= 1'b0;
      done_r <= 1'b0;
      branch_taken_r <= 1'b0;
      rom_addr_r <= '0;
      rom_req_r <= 1'b0;
    end else begin
      pc_load_r <= 1'b0;
      branch_taken_r <= 1'b0;
      rom_req_r <= accept && (op == OP_LDL || op == OP_LDH);
      done_r <= (state_r == S_EXEC) || (state_r == S_PUSH && last) ||
                (state_r == S_POP && cnt_r == nwords);
      if (accept) begin
        rom_addr_r <= {ROM_TABLE_MSB, dc_r}; // RULE_09 RULE_10
      end
      if (state_r == S_EXEC && writes_acc(op_r)) begin
        acc_r <= alu_bus.res; // RULE_16
      end
      if (state_r == S_EXEC && op_r == OP_BRANCH) begin
        branch_taken_r <= branch_condition_flag_r; // RULE_23
      end
      if (state_r == S_POP && cnt_r != 3'h0 && cnt_r <= CALL_WORDS) begin
        pc_acc_r <= {mem_val, pc_acc_r[11:4]};
      end
      if (state_r == S_POP && cnt_r == nwords) begin
        pc_load_r <= 1'b1; // RULE_02
        pc_out_r <= (op_r == OP_INTERRUPT_RETURN) ? pc_acc_r : {mem_val, pc_acc_r[11:4]};
      end
    end
  end

  // ==========================================================
  // checks
  a_sf_reset: assert property (@(posedge clk) $fell(rst) |-> branch_condition_flag_r) // RULE_24
    else $error("branch flag not set by reset");
  a_call_words: assert property (@(posedge clk) disable iff (rst) // RULE_01
    accept && op == OP_CALL |=> wr_any [*3] ##1 !wr_any)
    else $error("call did not write three words");
  a_int_words: assert property (@(posedge clk) disable iff (rst) // RULE_01
    accept && op == OP_INT |=> wr_any [*4] ##1 !wr_any)
    else $error("interrupt did not write four words");
  a_push_dec: assert property (@(posedge clk) disable iff (rst) // RULE_04
    state_r == S_PUSH && last && wr_addr != {1'b0, SLP_ADDR} |=> spw_r == $past(spw_r) - 4'h1)
    else $error("level pointer not decremented after save");
  a_pop_inc: assert property (@(posedge clk) disable iff (rst) // RULE_04
    accept && (op == OP_RET || op == OP_INTERRUPT_RETURN) |=> spw_r == $past(spw_r) + 4'h1)
    else $error("level pointer not incremented before restore");
  a_ret_time: assert property (@(posedge clk) disable iff (rst) // RULE_02
    accept && op == OP_RET |-> ##5 pc_load_r)
    else $error("return pc not loaded on time");
  a_interrupt_return_time: assert property (@(posedge clk) disable iff (rst) // RULE_02
    accept && op == OP_INTERRUPT_RETURN |-> !pc_load_r [*6] ##1 pc_load_r)
    else $error("interrupt return pc not loaded on time");
  a_testp_flags: assert property (@(posedge clk) disable iff (rst) // RULE_20
    state_r == S_EXEC && op_r == OP_CARRY_TEST_AND_SET |=>
    carry_flag_r && branch_condition_flag_r == $past(carry_flag_r))
    else $error("test-and-set flags wrong");
  a_test_flags: assert property (@(posedge clk) disable iff (rst) // RULE_21
    state_r == S_EXEC && op_r == OP_CARRY_TEST_AND_CLEAR |=>
    !carry_flag_r && branch_condition_flag_r != $past(carry_flag_r))
    else $error("test-and-clear flags wrong");
  a_branch_gate: assert property (@(posedge clk) disable iff (rst) // RULE_23
    branch_taken_r |-> $past(branch_condition_flag_r) && $past(op_r) == OP_BRANCH)
    else $error("branch taken without branch flag");
  a_rom_area: assert property (@(posedge clk) disable iff (rst) // RULE_10
    rom_req_r |-> rom_addr_r[12] && rom_addr_r[11:0] == $past(dc_r))
    else $error("table read outside table area");
  c_call: cover property (@(posedge clk) disable iff (rst) accept && op == OP_CALL);
  c_interrupt_return: cover property (@(posedge clk) disable iff (rst) pc_load_r && op_r == OP_INTERRUPT_RETURN);
  c_ldh: cover property (@(posedge clk) disable iff (rst) done_r && op_r == OP_LDH);
endmodule
`default_nettype wire

/* File: bench/tb_cpu_stack_alu_flags.sv */
// self-checking bench for the stack, table pointer, alu and flags core
// assumes csa_pkg and csa_core compiled first; drives the command port directly
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_stack_alu_flags import csa_pkg::*;;
  // ==========================================================
  // signals and state
  typedef struct {csa_op_type op; logic [3:0] imm; logic [3:0] acc; logic [2:0] fl;} csa_row_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  csa_op_type op = OP_NOP;
  logic [8:0] mem_addr = 9'h000;
  logic zero_page = 1'b0;
  logic [3:0] imm = 4'h0;
  logic [11:0] pc_in = 12'h000;
  logic [7:0] rom_data = 8'hA5;
  logic busy_r, done_r, carry_flag_r, zero_result_flag_r, branch_condition_flag_r;
  logic branch_taken_r, pc_load_r, rom_req_r;
  logic [3:0] acc_r;
  logic [11:0] pc_out_r;
  logic [12:0] rom_addr_r;
  logic [15:0] pc_cap, rom_cap;
  logic br_cap;
  int n_mismatch = 0;
  int checked = 0;
  csa_row_type rows [13];

  // ==========================================================
  // clock and design
  always #50 clk = ~clk;

  csa_core dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op), .mem_addr(mem_addr),
    .zero_page(zero_page), .imm(imm), .pc_in(pc_in), .rom_data(rom_data), .busy_r(busy_r),
    .done_r(done_r), .acc_r(acc_r), .carry_flag_r(carry_flag_r),
    .zero_result_flag_r(zero_result_flag_r), .branch_condition_flag_r(branch_condition_flag_r),
    .branch_taken_r(branch_taken_r), .pc_out_r(pc_out_r), .pc_load_r(pc_load_r),
    .rom_addr_r(rom_addr_r), .rom_req_r(rom_req_r));

  // ==========================================================
  // helpers
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one command, held for one clock, then bounded wait for done
  task automatic cmd(input csa_op_type o, input logic [8:0] a, input logic z,
      input logic [3:0] i, input logic [11:0] p);
    int k;
    @(posedge clk);
    op_valid <= 1'b1;
    op <= o;
    mem_addr <= a;
    zero_page <= z;
    imm <= i;
    pc_in <= p;
    pc_cap = 16'hFFFF;
    rom_cap = 16'hFFFF;
    @(posedge clk);
    op_valid <= 1'b0;
    // first look just after the taking edge, where the table read request stands
    for (k = 0; k < 20; k++) begin
      #1;
      if (rom_req_r === 1'b1) rom_cap = {3'h0, rom_addr_r};
      if (pc_load_r === 1'b1) pc_cap = {4'h0, pc_out_r};
      if (done_r === 1'b1) break;
      @(posedge clk);
    end
    br_cap = branch_taken_r;
    if (k == 20) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic op0(input csa_op_type o, input logic [3:0] i);
    cmd(o, 9'h007, 1'b0, i, 12'h000);
  endtask

  task automatic st(input logic [8:0] a, input logic [3:0] v);
    cmd(OP_ST_IMM_MEM, a, 1'b0, v, 12'h000);
  endtask

  task automatic rd(input logic [8:0] a, input logic [3:0] e);
    cmd(OP_LD_A_MEM, a, 1'b0, 4'h0, 12'h000);
    chk({12'h000, acc_r}, {12'h000, e});
  endtask

  function automatic logic [15:0] fl();
    return {13'h0000, carry_flag_r, zero_result_flag_r, branch_condition_flag_r};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    rows = '{'{OP_ADD_WITH_CARRY_MEM, 4'h0, 4'h2, 3'h4}, '{OP_REVERSE_SUBTRACT_WITH_CARRY_MEM, 4'h0, 4'h9, 3'h0},
      '{OP_COMPARE_OP_MEM, 4'h0, 4'hC, 3'h1}, '{OP_AND_MEM, 4'h0, 4'h4, 3'h5},
      '{OP_LD_A_MEM, 4'h0, 4'h5, 3'h5}, '{OP_LD_A_IMM, 4'h0, 4'h0, 3'h7},
      '{OP_ADD_IMM, 4'h4, 4'h0, 3'h6}, '{OP_DEC_A, 4'h0, 4'hB, 3'h5},
      '{OP_ROTATE_LEFT_THROUGH_CARRY, 4'h0, 4'h9, 3'h4}, '{OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h0, 4'hE, 3'h1},
      '{OP_OR_MEM, 4'h0, 4'hD, 3'h5}, '{OP_XOR_MEM, 4'h0, 4'h9, 3'h5},
      '{OP_COMPARE_OP_IMM, 4'hC, 4'hC, 3'h6}};
    repeat (10) @(posedge clk);
    #1;
    chk({busy_r, done_r, pc_load_r, rom_req_r, branch_taken_r, acc_r}, 16'h0000);
    chk({15'h0000, branch_condition_flag_r}, 16'h0001);
    @(posedge clk);
    rst <= 1'b0;
    op0(OP_COMPARE_OP_IMM, 4'h0); // carry and zero come out of reset unknown
    // table rows: acc C, word 07 = 5, carry 1 before each command
    foreach (rows[n]) begin
      st(9'h007, 4'h5);
      op0(OP_LD_A_IMM, 4'hC);
      op0(OP_CARRY_TEST_AND_SET, 4'h0);
      op0(rows[n].op, rows[n].imm);
      chk({12'h000, acc_r}, {12'h000, rows[n].acc});
      chk(fl(), {13'h0000, rows[n].fl});
    end
    // nested calls from level 12
    st(9'h0FF, 4'hC);
    st(9'h0EF, 4'h7);
    cmd(OP_CALL, 9'h000, 1'b0, 4'h0, 12'hABC);
    cmd(OP_CALL, 9'h000, 1'b0, 4'h0, 12'h123);
    rd(9'h0FF, 4'hA);
    for (int k = 0; k < 3; k++) rd(9'h0F0 + 9'(k), 4'(12'hABC >> (4 * k)));
    rd(9'h0EF, 4'h7);
    cmd(OP_RET, 9'h000, 1'b0, 4'h0, 12'h000);
    chk(pc_cap, 16'h0123);
    rd(9'h0FF, 4'hB);
    // interrupt saves flags, interrupt return restores them
    op0(OP_LD_A_IMM, 4'h0);
    op0(OP_CARRY_TEST_AND_CLEAR, 4'h0);
    op0(OP_CARRY_TEST_AND_SET, 4'h0);
    cmd(OP_INT, 9'h000, 1'b0, 4'h0, 12'h456);
    rd(9'h0EF, 4'h6);
    op0(OP_LD_A_IMM, 4'h5);
    op0(OP_CARRY_TEST_AND_CLEAR, 4'h0);
    cmd(OP_INTERRUPT_RETURN, 9'h000, 1'b0, 4'h0, 12'h000);
    chk(pc_cap, 16'h0456);
    chk(fl(), 16'h0006);
    cmd(OP_RET, 9'h000, 1'b0, 4'h0, 12'h000);
    chk(pc_cap, 16'h0ABC);
    chk(fl(), 16'h0006);
    // table pointer 780 then low and high reads
    st(9'h0FC, 4'h0);
    st(9'h0FD, 4'h8);
    st(9'h0FE, 4'h7);
    op0(OP_LDL, 4'h0);
    chk(rom_cap, 16'h1780);
    chk({12'h000, acc_r}, 16'h0005);
    op0(OP_LDH, 4'h0);
    chk({12'h000, acc_r}, 16'h000A);
    rd(9'h0FC, 4'h1);
    // branch follows the branch flag, which then returns to 1
    op0(OP_CARRY_TEST_AND_SET, 4'h0);
    op0(OP_CARRY_TEST_AND_CLEAR, 4'h0);
    chk(fl(), 16'h0000);
    op0(OP_BRANCH, 4'h0);
    chk({15'h0000, br_cap}, 16'h0000);
    op0(OP_BRANCH, 4'h0);
    chk({15'h0000, br_cap}, 16'h0001);
    // zero page, spare word, unguarded overflow
    cmd(OP_ST_IMM_MEM, 9'h1F3, 1'b1, 4'h9, 12'h000);
    rd(9'h003, 4'h9);
    st(9'h0F7, 4'h6);
    rd(9'h0F7, 4'h6);
    st(9'h0FB, 4'h3);
    rd(9'h0FB, 4'h3);
    st(9'h0F4, 4'h2);
    rd(9'h0F4, 4'h2);
    st(9'h0C0, 4'hF);
    st(9'h0FF, 4'h0);
    cmd(OP_CALL, 9'h000, 1'b0, 4'h0, 12'h5A1);
    rd(9'h0C0, 4'h1);
    // second reset keeps carry and zero
    op0(OP_CARRY_TEST_AND_CLEAR, 4'h0);
    op0(OP_CARRY_TEST_AND_SET, 4'h0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(fl(), 16'h0005);
    close_out();
  end
endmodule
`default_nettype wire
